// file: include/pcr_pkg.sv
// Shared constants and carriers for the second-PLL configuration bytes
package pcr_pkg;

  // Byte offsets of the bank
  localparam logic [7:0] PCR_OFS_INT_HI = 8'h10;
  localparam logic [7:0] PCR_OFS_INT_LO = 8'h11;
  localparam logic [7:0] PCR_OFS_FRAC_HI = 8'h12;
  localparam logic [7:0] PCR_OFS_FRAC_LO = 8'h13;
  localparam logic [7:0] PCR_OFS_STEP_LO = 8'h14;
  localparam logic [7:0] PCR_OFS_DELTA = 8'h15;
  localparam logic [7:0] PCR_OFS_STEP_HI = 8'h16;
  localparam logic [7:0] PCR_OFS_PER_LO = 8'h17;
  localparam logic [7:0] PCR_OFS_CTRL = 8'h18;

  // Bank geometry
  localparam int PCR_NUM_REGS = 9;
  localparam int PCR_IDX_W = 4;
  localparam logic [7:0] PCR_READ_ZERO = 8'h00;

  // Power-on values, indexed by offset minus the first offset
  localparam logic [7:0] PCR_RST_INT_HI = 8'h00;
  localparam logic [7:0] PCR_RST_INT_LO = 8'h3C;
  localparam logic [7:0] PCR_RST_ZERO = 8'h00;
  localparam logic [7:0] PCR_RST_CTRL = 8'h0E;
  localparam logic [PCR_NUM_REGS-1:0][7:0] PCR_RST_VALS = {
    PCR_RST_CTRL, PCR_RST_ZERO, PCR_RST_ZERO, PCR_RST_ZERO, PCR_RST_ZERO,
    PCR_RST_ZERO, PCR_RST_ZERO, PCR_RST_INT_LO, PCR_RST_INT_HI};

  // Writable-bit masks; clear bits are reserved and read zero
  localparam logic [7:0] PCR_MASK_INT_HI = 8'h07;
  localparam logic [7:0] PCR_MASK_FULL = 8'hFF;
  localparam logic [PCR_NUM_REGS-1:0][7:0] PCR_WMASKS = {
    PCR_MASK_FULL, PCR_MASK_FULL, PCR_MASK_FULL, PCR_MASK_FULL, PCR_MASK_FULL,
    PCR_MASK_FULL, PCR_MASK_FULL, PCR_MASK_FULL, PCR_MASK_INT_HI};

  // Filter resistor selects expected after power-on, bits 100k, 50k, 25k, 12k5 (100k off; 50k, 25k, 12k5 on)
  localparam logic [3:0] PCR_RST_FILTER = 4'h7;

  // Layout of the integer-divider upper byte
  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] int_hi;
  } pcr_int_hi_s;

  // Layout of the spread and loop-filter control byte
  typedef struct packed {
    logic [1:0] period_hi;
    logic spread_en;
    logic res_100k;
    logic res_50k;
    logic res_25k;
    logic res_12k5;
    logic res_6k;
  } pcr_ctrl_s;

  // Byte access from the serial host engine
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcr_req_s;

  // Settings driven to the analog PLL
  typedef struct packed {
    logic [10:0] pll2_int_div;
    logic [15:0] pll2_frac_div;
    logic [15:0] pll2_spread_step_size;
    logic [7:0] pll2_spread_step_delta;
    logic [9:0] pll2_spread_period;
    logic pll2_spread_enable;
    logic pll2_filter_res_100k_sel;
    logic pll2_filter_res_50k_sel;
    logic pll2_filter_res_25k_sel;
    logic pll2_filter_res_12k5_sel;
    logic pll2_filter_res_6k_only;
  } pcr_cfg_s;

endpackage

// file: core/pcr_byte_reg.sv
`timescale 1ns/100ps
`default_nettype none
// One configuration byte with power-on value and writable-bit mask
module pcr_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Write strobe and data
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  // Stored byte
  output logic [7:0] o_q
);

  logic [7:0] byte_d;
  logic [7:0] byte_q;

  // Masked bits keep their value, reserved bits stay zero
  always_comb begin
    byte_d = byte_q;
    if (i_wr) begin
      byte_d = (i_wdata & WMASK) | (byte_q & ~WMASK);
    end
  end

  // Register with power-on value
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      byte_q <= RESET_VAL & WMASK;
    end else begin
      byte_q <= byte_d;
    end
  end

  assign o_q = byte_q;

endmodule
`default_nettype wire

// file: core/pcr_top.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - 11-bit integer divider: bits 10..8 in 0x10[2:0], bits 7..0 in 0x11.
// - Integer divider low byte powers on 0x3C; upper three bits power on zero.
// - 16-bit fractional divider: high byte 0x12, low byte 0x13, resets zero.
// - 16-bit spread step: low byte 0x14, high byte 0x16, resets zero.
// - 8-bit spread step delta at 0x15, resets zero.
// - 10-bit spread period: bits 7..0 at 0x17, bits 9..8 in 0x18[7:6].
// - 0x18 bit 5 enables spread modulation; powers on disabled.
// - 0x18 bits 4..1 add filter resistors; power on 0,1,1,1.
// - 0x18 bit 0 applies only the 6k resistor; powers on clear.
module pcr_top
  import pcr_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Byte access from serial host engine
  input wire pcr_req_s i_req,
  // Read answer
  output logic o_rd_valid,
  output logic [7:0] o_rdata,
  // Settings to the analog PLL
  output pcr_cfg_s o_cfg
);

  logic in_range;
  logic [PCR_IDX_W-1:0] idx;
  logic [PCR_NUM_REGS-1:0] wr_sel;
  logic [PCR_NUM_REGS-1:0][7:0] regs;
  logic rd_valid_d;
  logic rd_valid_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  pcr_int_hi_s int_hi;
  pcr_ctrl_s ctrl;

  // Address decode into a bank index
  // range decode
  always_comb begin
    in_range = (i_req.addr >= PCR_OFS_INT_HI) && (i_req.addr <= PCR_OFS_CTRL);
    idx = PCR_IDX_W'(i_req.addr - PCR_OFS_INT_HI);
    wr_sel = '0;
    if (i_req.wr_en && in_range) begin
      wr_sel[idx] = 1'b1;
    end
  end

  // One byte cell per offset
  // power-on bytes
  for (genvar g = 0; g < PCR_NUM_REGS; g++) begin : g_bank
    pcr_byte_reg #(
      .RESET_VAL(PCR_RST_VALS[g]),
      .WMASK(PCR_WMASKS[g])
    ) u_byte (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_wr(wr_sel[g]),
      .i_wdata(i_req.wdata),
      .o_q(regs[g])
    );
  end

  // Read mux; unmapped offsets answer zero
  // read back
  always_comb begin
    rd_valid_d = i_req.rd_en;
    rdata_d = rdata_q;
    if (i_req.rd_en) begin
      rdata_d = in_range ? regs[idx] : PCR_READ_ZERO;
    end
  end

  // Read answer registers
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rd_valid_q <= 1'b0;
      rdata_q <= PCR_READ_ZERO;
    end else begin
      rd_valid_q <= rd_valid_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rd_valid = rd_valid_q;
  assign o_rdata = rdata_q;

  // Field views of the split bytes
  assign int_hi = pcr_int_hi_s'(regs[PCR_IDX_W'(PCR_OFS_INT_HI - PCR_OFS_INT_HI)]);
  assign ctrl = pcr_ctrl_s'(regs[PCR_IDX_W'(PCR_OFS_CTRL - PCR_OFS_INT_HI)]);

  // Assemble PLL settings straight from the byte flops
  // integer divider join
  assign o_cfg.pll2_int_div = {int_hi.int_hi,
    regs[PCR_IDX_W'(PCR_OFS_INT_LO - PCR_OFS_INT_HI)]};
  assign o_cfg.pll2_frac_div = {regs[PCR_IDX_W'(PCR_OFS_FRAC_HI - PCR_OFS_INT_HI)],
    regs[PCR_IDX_W'(PCR_OFS_FRAC_LO - PCR_OFS_INT_HI)]};
  assign o_cfg.pll2_spread_step_size = {regs[PCR_IDX_W'(PCR_OFS_STEP_HI - PCR_OFS_INT_HI)],
    regs[PCR_IDX_W'(PCR_OFS_STEP_LO - PCR_OFS_INT_HI)]};
  assign o_cfg.pll2_spread_step_delta = regs[PCR_IDX_W'(PCR_OFS_DELTA - PCR_OFS_INT_HI)];
  assign o_cfg.pll2_spread_period = {ctrl.period_hi,
    regs[PCR_IDX_W'(PCR_OFS_PER_LO - PCR_OFS_INT_HI)]};
  assign o_cfg.pll2_spread_enable = ctrl.spread_en;
  assign o_cfg.pll2_filter_res_100k_sel = ctrl.res_100k;
  assign o_cfg.pll2_filter_res_50k_sel = ctrl.res_50k;
  assign o_cfg.pll2_filter_res_25k_sel = ctrl.res_25k;
  assign o_cfg.pll2_filter_res_12k5_sel = ctrl.res_12k5;
  assign o_cfg.pll2_filter_res_6k_only = ctrl.res_6k;

  // Checks on the bank behaviour
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  a_int_hi_write: assert property (
    i_req.wr_en && i_req.addr == PCR_OFS_INT_HI
    |=> o_cfg.pll2_int_div[10:8] == $past(i_req.wdata[2:0]))
    else $error("integer divider upper bits not written");

  a_int_lo_reset: assert property (
    $past(i_srst) |-> o_cfg.pll2_int_div == {3'h0, PCR_RST_INT_LO})
    else $error("integer divider wrong after reset");

  a_frac_write: assert property (
    i_req.wr_en && i_req.addr == PCR_OFS_FRAC_HI
    |=> o_cfg.pll2_frac_div[15:8] == $past(i_req.wdata))
    else $error("fractional divider high byte not written");

  a_step_high: assert property (
    i_req.wr_en && i_req.addr == PCR_OFS_STEP_HI
    |=> o_cfg.pll2_spread_step_size[15:8] == $past(i_req.wdata)
        && $stable(o_cfg.pll2_spread_step_size[7:0]))
    else $error("step high byte wrong");

  a_delta_write: assert property (
    i_req.wr_en && i_req.addr == PCR_OFS_DELTA
    |=> o_cfg.pll2_spread_step_delta == $past(i_req.wdata))
    else $error("step delta not written");

  a_period_high: assert property (
    i_req.wr_en && i_req.addr == PCR_OFS_CTRL
    |=> o_cfg.pll2_spread_period[9:8] == $past(i_req.wdata[7:6]))
    else $error("period high bits not written");

  a_spread_off_reset: assert property (
    $past(i_srst) |-> !o_cfg.pll2_spread_enable)
    else $error("spread enabled after reset");

  a_filter_reset: assert property (
    $past(i_srst) |-> {o_cfg.pll2_filter_res_100k_sel, o_cfg.pll2_filter_res_50k_sel,
      o_cfg.pll2_filter_res_25k_sel, o_cfg.pll2_filter_res_12k5_sel} == PCR_RST_FILTER)
    else $error("filter resistors wrong after reset");

  a_res6k_write: assert property (
    i_req.wr_en && i_req.addr == PCR_OFS_CTRL
    |=> o_cfg.pll2_filter_res_6k_only == $past(i_req.wdata[0]))
    else $error("6k select not written");

  a_rsvd_zero: assert property (
    i_req.rd_en && i_req.addr == PCR_OFS_INT_HI
    |=> o_rd_valid && o_rdata[7:3] == 5'h00)
    else $error("reserved bits read nonzero");

  a_read_back: assert property (
    i_req.wr_en && i_req.addr == PCR_OFS_DELTA
    ##1 i_req.rd_en && !i_req.wr_en && i_req.addr == PCR_OFS_DELTA
    |=> o_rd_valid && o_rdata == $past(i_req.wdata, 2))
    else $error("read back differs from write");

  a_unmapped_zero: assert property (
    i_req.rd_en && !in_range |=> o_rd_valid && o_rdata == PCR_READ_ZERO)
    else $error("unmapped read not zero");

  a_rd_valid_pulse: assert property (
    o_rd_valid |-> $past(i_req.rd_en))
    else $error("read valid without a read strobe");

  // Main scenarios
  c_spread_on: cover property (
    i_req.wr_en && i_req.addr == PCR_OFS_CTRL ##1 o_cfg.pll2_spread_enable);
  c_unmapped_rd: cover property (i_req.rd_en && !in_range);
  c_int_lo_rd: cover property (i_req.rd_en && i_req.addr == PCR_OFS_INT_LO);
  c_rd_wr_same: cover property (i_req.rd_en && i_req.wr_en && in_range);
  c_wr_then_rd: cover property (
    i_req.wr_en && in_range ##1 i_req.rd_en && !i_req.wr_en && in_range);

endmodule
`default_nettype wire

// file: testbench/pcr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Stand-in for the serial host byte engine
module pcr_host_model
  import pcr_pkg::*;
(
  // Clock
  input wire logic i_core_clk,
  // Read answer from the bank
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rdata,
  // Byte request to the bank
  output pcr_req_s o_req
);
  // Idle request from time zero
  initial begin
    o_req = '0;
  end

  // One strobe for one cycle, then released with inverted address and data
  task automatic xfer(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(negedge i_core_clk);
    o_req = '{wr_en: w, rd_en: r, addr: a, wdata: d};
    @(negedge i_core_clk);
    o_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
    // Answer only counts when the valid flag matches the read strobe
    q = (i_rd_valid === r) ? i_rdata : 8'hxx;
  endtask

  // Write then read of one byte on consecutive cycles, answer taken after the read
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge i_core_clk);
    o_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(negedge i_core_clk);
    o_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: ~d};
    @(negedge i_core_clk);
    o_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
    q = (i_rd_valid === 1'b1) ? i_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_pll2_config_register_bank.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the second-PLL configuration bytes
module tb_pll2_config_register_bank
  import pcr_pkg::*;
;
  logic i_core_clk;
  logic i_srst;
  pcr_req_s req;
  logic rd_valid;
  logic [7:0] rdata;
  pcr_cfg_s cfg;
  logic [7:0] v [9];
  logic [7:0] q;
  logic [7:0] w;
  int bad_count;
  int total_checks;

  // Design under test
  pcr_top uut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_req(req),
    .o_rd_valid(rd_valid), .o_rdata(rdata), .o_cfg(cfg));

  // Host side of the byte bus
  pcr_host_model host (.i_core_clk(i_core_clk), .i_rd_valid(rd_valid),
    .i_rdata(rdata), .o_req(req));

  // 125 MHz clock
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  // Settings expected from the byte image in v
  function automatic logic [66:0] cfg_of();
    return {v[0][2:0], v[1], v[2], v[3], v[6], v[4], v[5], v[8][7:6], v[7], v[8][5:0]};
  endfunction

  // Compare and count
  task automatic check(input logic [66:0] got, input logic [66:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Read back every byte and the settings bus
  task automatic check_all(input string what);
    for (int i = 0; i < 9; i++) begin
      host.xfer(1'b0, 1'b1, 8'h10 + 8'(i), 8'h00, q);
      check(67'(q), 67'(v[i]), what);
    end
    check(cfg, cfg_of(), what);
    $display("test %s done", what);
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected run of about 1.3 microseconds
  initial begin
    #20_000;
    bad_count++;
    complete_run();
  end

  // Test sequence
  initial begin
    i_srst = 1'b1;
    bad_count = 0;
    total_checks = 0;
    repeat (4) @(negedge i_core_clk);
    i_srst = 1'b0;
    v = '{8'h00, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0E};
    check_all("power-on");
    // Pattern and its inverse into every byte
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 9; i++) begin
        w = 8'hC3 ^ (8'h11 * 8'(i));
        if (p == 1) begin
          w = ~w;
        end
        host.xfer(1'b1, 1'b0, 8'h10 + 8'(i), w, q);
        v[i] = (i == 0) ? (w & 8'h07) : w;
      end
      check_all("write pass");
    end
    // Unmapped neighbours are inert and 0x19 reads zero
    host.xfer(1'b1, 1'b0, 8'h0F, 8'hFF, q);
    host.xfer(1'b1, 1'b0, 8'h19, 8'hFF, q);
    host.xfer(1'b0, 1'b1, 8'h19, 8'h00, q);
    check(67'(q), 67'(8'h00), "unmapped read");
    check_all("unmapped");
    // Read and write of one byte in the same cycle
    host.xfer(1'b1, 1'b1, 8'h15, 8'h5A, q);
    check(67'(q), 67'(v[5]), "read during write");
    v[5] = 8'h5A;
    check_all("read during write");
    // Write then read of one byte on consecutive cycles
    host.wr_rd(PCR_OFS_DELTA, 8'hA5, q);
    check(67'(q), 67'(8'hA5), "write then read");
    v[5] = 8'hA5;
    check(cfg, cfg_of(), "write then read");
    $display("test write then read done");
    // Reset in mid-run restores power-on values
    @(negedge i_core_clk);
    i_srst = 1'b1;
    repeat (4) @(negedge i_core_clk);
    i_srst = 1'b0;
    v = '{8'h00, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0E};
    check_all("second reset");
    complete_run();
  end
endmodule
`default_nettype wire
